/* src/pwm_scaler_pkg.sv */
// constants and types shared by the pwm clock scaler and channel clock select
package pwm_scaler_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;
  localparam int NUM_CH  = 8;
  localparam int NUM_SCL = 2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFF_SCALE_A  = 3'h0;
  localparam logic [2:0] OFF_SCALE_B  = 3'h1;
  localparam logic [2:0] OFF_CLK_SEL  = 3'h2;
  localparam logic [2:0] OFF_PAIR_SEL = 3'h3;
  localparam logic [2:0] OFF_STATUS   = 3'h4;
  localparam logic [2:0] OFF_COUNT_A  = 3'h5;
  localparam logic [2:0] OFF_COUNT_B  = 3'h6;

  // ---------------------------------------------------------------
  // reset values and counter constants
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SCALE    = 8'h00;
  localparam logic [7:0] RST_CLK_SEL  = 8'h00;
  localparam logic [7:0] RST_PAIR_SEL = 8'h00;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] COUNT_ONE    = 8'h01;
  localparam logic [7:0] COUNT_DEC    = 8'h01;
  localparam logic [7:0] READ_IDLE    = 8'h00;
  // channels whose pair bit at zero means the b family (2, 3, 6, 7)
  localparam logic [7:0] B_DEFAULT_MASK = 8'hcc;

  // ---------------------------------------------------------------
  // status register field positions
  // ---------------------------------------------------------------
  localparam int STAT_TOGGLE_A = 0;
  localparam int STAT_TOGGLE_B = 1;
  localparam int STAT_SA       = 2;
  localparam int STAT_SB       = 3;

  // ---------------------------------------------------------------
  // channel clock sources
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_A  = 2'b00,
    SRC_SA = 2'b01,
    SRC_B  = 2'b10,
    SRC_SB = 2'b11
  } clk_src_type;

endpackage

/* src/pwm_clock_scaler_select.sv */
// clock scalers a/b and per-channel clock selection of an eight-channel pwm
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module pwm_clock_scaler_select (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       clk_a_en_in,
  input  wire logic       clk_b_en_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            sa_en_out,
  output logic            sb_en_out,
  output logic      [7:0] chan_clk_en_out
);

  // every check below runs on the bus clock; all but the two reset clock selection checks sleep through reset
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  function automatic pwm_scaler_pkg::clk_src_type choose_src(
    input logic b_default,
    input logic scaled,
    input logic pair
  );
    logic use_b;
    use_b = pair ^ b_default;
    if (use_b) begin
      choose_src = scaled ? pwm_scaler_pkg::SRC_SB : pwm_scaler_pkg::SRC_B;
    end else begin
      choose_src = scaled ? pwm_scaler_pkg::SRC_SA : pwm_scaler_pkg::SRC_A;
    end
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [1:0][7:0]             scale_reg;
  logic [1:0][7:0]             count_reg;
  logic [1:0]                  toggle_reg;
  logic [1:0]                  scaled_reg;
  logic [1:0]                  scaled_next;
  logic [1:0]                  expire;
  logic [1:0]                  tick;
  logic [1:0]                  wr_scale;
  logic [7:0]                  clk_sel_reg;
  logic [7:0]                  pair_sel_reg;
  logic [7:0]                  chan_reg;
  logic [7:0]                  chan_next;
  logic [7:0]                  rdata_reg;
  logic [7:0]                  rdata_next;
  pwm_scaler_pkg::clk_src_type src_sel [pwm_scaler_pkg::NUM_CH];

  // upstream prescaler strobes share this clock, so no synchroniser
  assign tick        = {clk_b_en_in, clk_a_en_in};
  assign wr_scale[0] = wr_in && (addr_in == pwm_scaler_pkg::OFF_SCALE_A);
  assign wr_scale[1] = wr_in && (addr_in == pwm_scaler_pkg::OFF_SCALE_B);

  // ---------------------------------------------------------------
  // scalers: index 0 is a, index 1 is b
  // ---------------------------------------------------------------
  for (genvar k = 0; k < pwm_scaler_pkg::NUM_SCL; k++) begin : g_scl
    // a write wins over a tick so the new rate starts cleanly
    assign expire[k]      = tick[k] && !wr_scale[k] &&
                            (count_reg[k] == pwm_scaler_pkg::COUNT_ONE);
    assign scaled_next[k] = expire[k] && toggle_reg[k];

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        scale_reg[k] <= pwm_scaler_pkg::RST_SCALE;
      end else if (wr_scale[k]) begin
        scale_reg[k] <= wdata_in;
      end
    end

    // zero wraps through 255 down to one: 256 ticks per pulse
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        count_reg[k] <= pwm_scaler_pkg::RST_COUNT;
      end else if (wr_scale[k]) begin
        count_reg[k] <= wdata_in;
      end else if (expire[k]) begin
        count_reg[k] <= scale_reg[k];
      end else if (tick[k]) begin
        count_reg[k] <= count_reg[k] - pwm_scaler_pkg::COUNT_DEC;
      end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        toggle_reg[k] <= 1'b0;
      end else if (expire[k]) begin
        toggle_reg[k] <= ~toggle_reg[k];
      end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        scaled_reg[k] <= 1'b0;
      end else begin
        scaled_reg[k] <= scaled_next[k];
      end
    end

    a_count_dec: assert property (tick[k] && !wr_scale[k] && !expire[k]
      |=> count_reg[k] == $past(count_reg[k]) - pwm_scaler_pkg::COUNT_DEC)
      else $error("scale counter did not step down on a tick");
    a_count_reload: assert property (expire[k]
      |=> count_reg[k] == $past(scale_reg[k]))
      else $error("scale counter did not reload at one");
    a_pulse_halved: assert property (scaled_reg[k]
      |-> !toggle_reg[k] && $past(expire[k]) && $past(toggle_reg[k]))
      else $error("scaled strobe not on every second pulse");
    a_zero_full: assert property (count_reg[k] == 8'h00 && tick[k] && !wr_scale[k]
      |=> count_reg[k] == 8'hff && !scaled_reg[k])
      else $error("zero scale did not count as full scale");
    a_write_reload: assert property (wr_scale[k]
      |=> count_reg[k] == $past(wdata_in) && scale_reg[k] == $past(wdata_in))
      else $error("scale write did not reload counter");
    a_strobe_single: assert property (scaled_reg[k] |=> !scaled_reg[k])
      else $error("scaled strobe longer than one cycle");

    // toggle keeps its phase over a scale write, so one period may run long
    a_toggle_flip: assert property (expire[k]
      |=> toggle_reg[k] != $past(toggle_reg[k]))
      else $error("halving stage did not flip on a pulse");
    a_toggle_hold: assert property (!expire[k]
      |=> toggle_reg[k] == $past(toggle_reg[k]))
      else $error("halving stage flipped without a pulse");
    a_count_idle: assert property (!tick[k] && !wr_scale[k]
      |=> $stable(count_reg[k]))
      else $error("scale counter moved without a tick");
    a_scale_hold: assert property (!wr_scale[k]
      |=> $stable(scale_reg[k]))
      else $error("scale value changed without a write");
    a_strobe_tick: assert property (scaled_reg[k]
      |-> $past(tick[k]) && $past(count_reg[k]) == pwm_scaler_pkg::COUNT_ONE)
      else $error("scaled strobe not on an expiring tick");
    a_no_tick_quiet: assert property (!tick[k]
      |=> !scaled_reg[k])
      else $error("scaled strobe without a source tick");
    a_write_quiet: assert property (wr_scale[k]
      |=> !scaled_reg[k])
      else $error("scale write let a strobe through");
  end

  // ---------------------------------------------------------------
  // channel clock selection
  // ---------------------------------------------------------------
  for (genvar i = 0; i < pwm_scaler_pkg::NUM_CH; i++) begin : g_ch
    assign src_sel[i] = choose_src(pwm_scaler_pkg::B_DEFAULT_MASK[i],
                                   clk_sel_reg[i], pair_sel_reg[i]);

    always_comb begin
      case (src_sel[i])
        pwm_scaler_pkg::SRC_A:  chan_next[i] = clk_a_en_in;
        pwm_scaler_pkg::SRC_SA: chan_next[i] = scaled_next[0];
        pwm_scaler_pkg::SRC_B:  chan_next[i] = clk_b_en_in;
        pwm_scaler_pkg::SRC_SB: chan_next[i] = scaled_next[1];
        default:                chan_next[i] = 1'b0;
      endcase
    end

    // registered so every source shows the same one-cycle latency
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        chan_reg[i] <= 1'b0;
      end else begin
        chan_reg[i] <= chan_next[i];
      end
    end

    a_chan_sa: assert property (chan_reg[i] &&
      $past(src_sel[i]) == pwm_scaler_pkg::SRC_SA |-> scaled_reg[0])
      else $error("channel strobe without clock sa");
    a_chan_sb: assert property (chan_reg[i] &&
      $past(src_sel[i]) == pwm_scaler_pkg::SRC_SB |-> scaled_reg[1])
      else $error("channel strobe without clock sb");

    // both ways per source, so a dead or stuck strobe is caught too
    a_chan_a: assert property ($past(src_sel[i]) == pwm_scaler_pkg::SRC_A
      |-> chan_reg[i] == $past(clk_a_en_in))
      else $error("channel on clock a does not follow it");
    a_chan_b: assert property ($past(src_sel[i]) == pwm_scaler_pkg::SRC_B
      |-> chan_reg[i] == $past(clk_b_en_in))
      else $error("channel on clock b does not follow it");
    a_chan_scaled: assert property (
      ($past(src_sel[i]) == pwm_scaler_pkg::SRC_SA |-> chan_reg[i] == scaled_reg[0]) and
      ($past(src_sel[i]) == pwm_scaler_pkg::SRC_SB |-> chan_reg[i] == scaled_reg[1]))
      else $error("channel on a scaled clock does not follow it");
    a_reset_chan: assert property (@(posedge sys_clk_in) disable iff (1'b0)
      $fell(rst_in) |-> src_sel[i] == (pwm_scaler_pkg::B_DEFAULT_MASK[i] ?
        pwm_scaler_pkg::SRC_B : pwm_scaler_pkg::SRC_A))
      else $error("channel reset clock selection wrong");
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // selection changes mid-period can clip a channel's count
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_sel_reg <= pwm_scaler_pkg::RST_CLK_SEL;
    end else if (wr_in && addr_in == pwm_scaler_pkg::OFF_CLK_SEL) begin
      clk_sel_reg <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pair_sel_reg <= pwm_scaler_pkg::RST_PAIR_SEL;
    end else if (wr_in && addr_in == pwm_scaler_pkg::OFF_PAIR_SEL) begin
      pair_sel_reg <= wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = pwm_scaler_pkg::READ_IDLE;
    if (rd_in) begin
      case (addr_in)
        pwm_scaler_pkg::OFF_SCALE_A:  rdata_next = scale_reg[0];
        pwm_scaler_pkg::OFF_SCALE_B:  rdata_next = scale_reg[1];
        pwm_scaler_pkg::OFF_CLK_SEL:  rdata_next = clk_sel_reg;
        pwm_scaler_pkg::OFF_PAIR_SEL: rdata_next = pair_sel_reg;
        pwm_scaler_pkg::OFF_STATUS: begin
          rdata_next[pwm_scaler_pkg::STAT_TOGGLE_A] = toggle_reg[0];
          rdata_next[pwm_scaler_pkg::STAT_TOGGLE_B] = toggle_reg[1];
          rdata_next[pwm_scaler_pkg::STAT_SA]       = scaled_reg[0];
          rdata_next[pwm_scaler_pkg::STAT_SB]       = scaled_reg[1];
        end
        pwm_scaler_pkg::OFF_COUNT_A:  rdata_next = count_reg[0];
        pwm_scaler_pkg::OFF_COUNT_B:  rdata_next = count_reg[1];
        default:                      rdata_next = pwm_scaler_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= pwm_scaler_pkg::READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out       = rdata_reg;
  assign sa_en_out       = scaled_reg[0];
  assign sb_en_out       = scaled_reg[1];
  assign chan_clk_en_out = chan_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sa_from_a: assert property (scaled_reg[0] |-> $past(clk_a_en_in))
    else $error("clock sa strobe without a clock a tick");
  a_sb_from_b: assert property (scaled_reg[1] |-> $past(clk_b_en_in))
    else $error("clock sb strobe without a clock b tick");
  a_reset_sel: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    $fell(rst_in) |-> src_sel[0] == pwm_scaler_pkg::SRC_A &&
      src_sel[2] == pwm_scaler_pkg::SRC_B && src_sel[5] == pwm_scaler_pkg::SRC_A &&
      src_sel[7] == pwm_scaler_pkg::SRC_B)
    else $error("reset clock selection wrong");

  a_sel_write: assert property (wr_in && addr_in == pwm_scaler_pkg::OFF_CLK_SEL
    |=> clk_sel_reg == $past(wdata_in))
    else $error("scaled choice bits not written");
  a_pair_write: assert property (wr_in && addr_in == pwm_scaler_pkg::OFF_PAIR_SEL
    |=> pair_sel_reg == $past(wdata_in))
    else $error("pair choice bits not written");
  a_read_count: assert property (rd_in && addr_in == pwm_scaler_pkg::OFF_COUNT_A
    |=> rdata_reg == $past(count_reg[0]))
    else $error("counter a read back wrong");
  // read data stand one cycle only, so stale data never look fresh
  a_rdata_once: assert property (!$past(rd_in) |-> rdata_reg == pwm_scaler_pkg::READ_IDLE)
    else $error("read data outside the cycle after a read");

  c_sa_strobe: cover property (scaled_reg[0]);
  c_sb_strobe: cover property (scaled_reg[1]);
  c_zero_scale: cover property (wr_scale[0] && wdata_in == 8'h00);
  c_chan_sb: cover property (chan_reg[2] && $past(src_sel[2]) == pwm_scaler_pkg::SRC_SB);
  c_full_wrap: cover property (count_reg[0] == 8'h00 && tick[0]);

endmodule

/* tb/prescale_tick_model.sv */
// upstream prescaler model: makes clock a or clock b ticks on the bus clock
`timescale 1ns/10ps
module prescale_tick_model (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic [1:0] period_in,
  output logic            tick_out
);
  logic [1:0] cnt_reg;
  initial tick_out = 1'b0;
  // ticks stop dead while halted, so every restart has a known phase
  always @(posedge clk_in) begin
    if (!run_in) begin
      cnt_reg  <= 2'h0;
      tick_out <= 1'b0;
    end else begin
      cnt_reg  <= (cnt_reg + 2'h1 >= period_in) ? 2'h0 : cnt_reg + 2'h1;
      tick_out <= (cnt_reg == 2'h0);
    end
  end
endmodule

/* tb/tb_pwm_clock_scaler_select.sv */
// self-checking bench for the pwm clock scaler and channel clock select
`timescale 1ns/10ps
`define check(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_pwm_clock_scaler_select;
  logic       sys_clk_in, rst_in, wr_in, rd_in, rd_seen, sa_en_out, sb_en_out;
  logic       clk_a_en_in, clk_b_en_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, chan_clk_en_out, clk_sel, pair_sel, ub, v;
  logic [7:0] rd_exp;
  logic [7:0] rd_q[$];
  logic [7:0] scales[3];
  logic [1:0] run, p;
  logic [1:0] per[2];
  int         exp_q[2][$];
  int         last[2], cnt_src[4], cnt_ch[8];
  int         cyc, num_errors, compares, gap_exp;
  wire  [1:0] scl = {sb_en_out, sa_en_out};

  pwm_clock_scaler_select DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .clk_a_en_in(clk_a_en_in), .clk_b_en_in(clk_b_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sa_en_out(sa_en_out), .sb_en_out(sb_en_out), .chan_clk_en_out(chan_clk_en_out));
  prescale_tick_model tick_a (.clk_in(sys_clk_in), .run_in(run[0]), .period_in(per[0]),
    .tick_out(clk_a_en_in));
  prescale_tick_model tick_b (.clk_in(sys_clk_in), .run_in(run[1]), .period_in(per[1]),
    .tick_out(clk_b_en_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic conclude();
    $display("compares %0d, num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one bus cycle; for a read, d is the expected data
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr_in   <= w;
    rd_in   <= !w;
    addr_in <= a;
    wdata_in <= d;
    if (!w) rd_q.push_back(d);
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask

  task automatic wait_pulse(input int k);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (!scl[k] && n < 2000);
    if (!scl[k]) num_errors++;
  endtask

  // ---------------------------------------------------------------
  // monitor: read data, scaled strobe spacing, pulse counts
  // ---------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
    if (rd_seen) begin
      rd_exp = rd_q.pop_front();
      `check(rdata_out, rd_exp)
    end
    rd_seen <= rd_in;
    for (int k = 0; k < 2; k++) begin
      if (scl[k]) begin
        if (exp_q[k].size() > 0) begin
          gap_exp = exp_q[k].pop_front();
          `check(cyc - last[k], gap_exp)
        end
        last[k] = cyc;
      end
    end
    cnt_src[0] += clk_a_en_in;
    cnt_src[1] += sa_en_out;
    cnt_src[2] += clk_b_en_in;
    cnt_src[3] += sb_en_out;
    for (int i = 0; i < 8; i++) cnt_ch[i] += chan_clk_en_out[i];
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    {wr_in, rd_in, rd_seen, addr_in, wdata_in, run, clk_sel, pair_sel} = '0;
    per = '{2'h1, 2'h1};
    rst_in = 1'b1;
    void'($urandom(67));
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (int j = 0; j < 8; j++) bus(1'b0, 3'(j), 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      bus(1'b1, 3'(k), v);
      bus(1'b0, 3'(k + 5), v);
      bus(1'b0, 3'(k), v);
    end
    scales = '{8'h01, 8'h00, 8'($urandom_range(255, 2))};
    foreach (scales[j]) for (int k = 0; k < 2; k++) begin
      p = 2'($urandom_range(3, 1));
      run <= 2'b00;
      bus(1'b1, 3'(k), scales[j]);
      per[k] <= p;
      run[k] <= 1'b1;
      wait_pulse(k);
      wait_pulse(k);
      exp_q[k].push_back(2 * (scales[j] == 8'h00 ? 256 : scales[j]) * p);
      wait_pulse(k);
    end
    run <= 2'b00;
    bus(1'b1, 3'h0, 8'h01);
    bus(1'b1, 3'h1, 8'h02);
    for (int it = 0; it < 4; it++) begin
      run <= 2'b00;
      if (it > 0) begin
        clk_sel = 8'($urandom);
        pair_sel = 8'($urandom);
        bus(1'b1, 3'h2, clk_sel);
        bus(1'b1, 3'h3, pair_sel);
        bus(1'b0, 3'h2, clk_sel);
      end
      repeat (4) @(negedge sys_clk_in);
      cnt_src = '{default: 0};
      cnt_ch = '{default: 0};
      per <= '{2'h1, 2'h3};
      run <= 2'b11;
      repeat (120) @(negedge sys_clk_in);
      run <= 2'b00;
      repeat (6) @(negedge sys_clk_in);
      ub = pair_sel ^ 8'hcc;
      for (int i = 0; i < 8; i++) `check(cnt_ch[i], cnt_src[{ub[i], clk_sel[i]}])
    end
    `check(exp_q[0].size() + exp_q[1].size() + rd_q.size(), 0)
    conclude();
  end
endmodule
